// >>> rtl/flash_guard_params.svh
// Register map, field positions, key codes and timing constants of the flash write and lock guard.
`ifndef FLASH_GUARD_PARAMS_SVH
`define FLASH_GUARD_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define FG_OFS_CONTROL       8'h00
`define FG_OFS_KEY           8'h04
`define FG_OFS_RESET_SOURCE  8'h08
`define FG_OFS_WRITE_CYCLES  8'h0c
`define FG_OFS_ERASE_CYCLES  8'h10
`define FG_OFS_STATUS        8'h14

// ==========================================================
// Field positions
`define FG_BIT_WRITE_ENABLE  0
`define FG_BIT_ERASE_ENABLE  1
`define FG_BIT_SUPPLY_SEL    1
`define FG_BIT_FLASH_ERROR   6
`define FG_BIT_BUSY          0
`define FG_BIT_ANY_LOCKED    1
`define FG_LOCK_FIELD_LSB    8
`define FG_PAGE_LSB          9
`define FG_PAGE_MSB          13

// ==========================================================
// Key codes, addresses and values
`define FG_KEY_FIRST         8'ha5
`define FG_KEY_SECOND        8'hf1
`define FG_RESERVED_BASE     16'h3e00
`define FG_LOCK_BYTE_ADDR    16'h3dff
`define FG_ERASED_BYTE       8'hff
`define FG_CONTROL_RESET     1'b0
`define FG_SUPPLY_SEL_RESET  1'b0

// ==========================================================
// Timing
`define FG_CLK_PERIOD_NS     8
`define FG_WRITE_TIME_NS     40000
`define FG_ERASE_TIME_NS     10000000
`define FG_WRITE_CYCLES      ((`FG_WRITE_TIME_NS + `FG_CLK_PERIOD_NS - 1) / `FG_CLK_PERIOD_NS)
`define FG_ERASE_CYCLES      ((`FG_ERASE_TIME_NS + `FG_CLK_PERIOD_NS - 1) / `FG_CLK_PERIOD_NS)

`endif

// >>> rtl/flash_guard_pkg.sv
// Types shared by the flash write and lock guard.
package flash_guard_pkg;

	// Unlock state, codes as read back from the key register
	typedef enum logic [1:0] {
		key_locked   = 2'b00,
		key_first    = 2'b01,
		key_unlocked = 2'b10,
		key_disabled = 2'b11
	} key_state_e;

	// Debug port commands
	typedef enum logic [1:0] {
		dbg_read         = 2'b00,
		dbg_write        = 2'b01,
		dbg_page_erase   = 2'b10,
		dbg_device_erase = 2'b11
	} dbg_cmd_e;

	// Operation timer phase
	typedef enum logic {
		timer_idle = 1'b0,
		timer_run  = 1'b1
	} timer_state_e;

endpackage

// >>> rtl/flash_op_timer.sv
// Cycle timer that stalls the core for one flash write or erase.
`timescale 1ns/10ps
`default_nettype none

module flash_op_timer #(
	parameter int COUNT_W = 24
) (
	input  wire logic               core_clk,
	input  wire logic               rst_n,
	input  wire logic               ce,
	input  wire logic               start,
	input  wire logic               is_erase,
	input  wire logic [COUNT_W-1:0] write_cycles,
	input  wire logic [COUNT_W-1:0] erase_cycles,
	output logic                    busy
);

	typedef struct packed {
		flash_guard_pkg::timer_state_e state;
		logic [COUNT_W-1:0]            count;
	} timer_s;

	timer_s s_ff;
	timer_s nxt_s;

	// Load the chosen count and run it down; busy stands for exactly that count, or for one cycle when the count is zero
	always_comb begin
		nxt_s = s_ff;
		case (s_ff.state)
			flash_guard_pkg::timer_idle: begin
				if (start) begin
					nxt_s.state = flash_guard_pkg::timer_run;
					nxt_s.count = is_erase ? erase_cycles : write_cycles;
				end
			end
			flash_guard_pkg::timer_run: begin
				if (s_ff.count <= COUNT_W'(1)) begin
					nxt_s.state = flash_guard_pkg::timer_idle;
					nxt_s.count = '0;
				end else begin
					nxt_s.count = s_ff.count - COUNT_W'(1);
				end
			end
			default: begin
				nxt_s = '{state: flash_guard_pkg::timer_idle, count: '0};
			end
		endcase
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_ff <= '{state: flash_guard_pkg::timer_idle, count: '0};
		end else if (ce) begin
			s_ff <= nxt_s;
		end
	end

	assign busy = (s_ff.state == flash_guard_pkg::timer_run);

endmodule

`default_nettype wire

// >>> rtl/flash_write_and_lock_guard.sv
// Flash unlock, write and erase sequencing with page lock protection and an Avalon-MM register slave.
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "flash_guard_params.svh"

module flash_write_and_lock_guard #(
	parameter int COUNT_W      = 24,
	parameter int WRITE_CYCLES = `FG_WRITE_CYCLES,
	parameter int ERASE_CYCLES = `FG_ERASE_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        core_xwr_valid,
	input  wire logic [15:0] core_xwr_addr,
	input  wire logic [7:0]  core_xwr_data,
	input  wire logic        core_xrd_valid,
	input  wire logic [15:0] core_xrd_addr,
	input  wire logic        core_cread_valid,
	input  wire logic [15:0] core_cread_addr,
	input  wire logic [15:0] core_exec_addr,
	input  wire logic [7:0]  lock_byte_value,
	input  wire logic        last_reset_flash_error,
	input  wire logic        supply_monitor_on,
	input  wire logic        dbg_req,
	input  wire logic [1:0]  dbg_cmd,
	input  wire logic [15:0] dbg_addr,
	input  wire logic [7:0]  dbg_wdata,
	output logic             core_stall,
	output logic             irq_hold,
	output logic             ram_we,
	output logic             ram_re,
	output logic      [15:0] ram_addr,
	output logic      [7:0]  ram_wdata,
	output logic             flash_we,
	output logic             flash_erase,
	output logic             flash_mass_erase,
	output logic      [13:0] flash_addr,
	output logic      [7:0]  flash_wdata,
	output logic             flash_error_device_reset,
	output logic             dbg_grant,
	output logic             dbg_ignored
);

	// ==========================================================
	// State

	typedef struct packed {
		logic                        avs_wait;
		logic [31:0]                 avs_rdata;
		logic                        write_enable;
		logic                        erase_enable;
		flash_guard_pkg::key_state_e key;
		logic                        supply_sel;
		logic                        err_flag;
		logic [COUNT_W-1:0]          wr_cycles;
		logic [COUNT_W-1:0]          er_cycles;
		logic [7:0]                  lock_eff;
		logic                        loaded;
		logic                        mon_meta;
		logic                        mon_sync;
		logic                        ram_we;
		logic                        ram_re;
		logic [15:0]                 ram_addr;
		logic [7:0]                  ram_wdata;
		logic                        fl_we;
		logic                        fl_erase;
		logic                        fl_mass;
		logic [13:0]                 fl_addr;
		logic [7:0]                  fl_wdata;
		logic                        err_reset;
		logic                        dbg_grant;
		logic                        dbg_ignored;
	} guard_s;

	localparam guard_s RESET_S = '{
		avs_wait:     1'b1,
		avs_rdata:    32'h0000_0000,
		write_enable: `FG_CONTROL_RESET,
		erase_enable: `FG_CONTROL_RESET,
		key:          flash_guard_pkg::key_locked,
		supply_sel:   `FG_SUPPLY_SEL_RESET,
		err_flag:     1'b0,
		wr_cycles:    COUNT_W'(WRITE_CYCLES),
		er_cycles:    COUNT_W'(ERASE_CYCLES),
		lock_eff:     `FG_ERASED_BYTE,
		loaded:       1'b0,
		mon_meta:     1'b0,
		mon_sync:     1'b0,
		ram_we:       1'b0,
		ram_re:       1'b0,
		ram_addr:     16'h0000,
		ram_wdata:    8'h00,
		fl_we:        1'b0,
		fl_erase:     1'b0,
		fl_mass:      1'b0,
		fl_addr:      14'h0000,
		fl_wdata:     8'h00,
		err_reset:    1'b0,
		dbg_grant:    1'b0,
		dbg_ignored:  1'b0
	};

	guard_s s_ff;
	guard_s nxt_s;
	logic   busy;
	logic   op_start;
	logic   op_is_erase;

	// ==========================================================
	// Helpers

	// Page number of a flash address
	function automatic logic [4:0] page_of(input logic [15:0] addr);
		page_of = addr[`FG_PAGE_MSB:`FG_PAGE_LSB];
	endfunction

	// Reserved page and everything beyond the flash
	function automatic logic is_reserved(input logic [15:0] addr);
		is_reserved = (addr >= `FG_RESERVED_BASE);
	endfunction

	// Page held by the lock: counted pages from zero plus the lock page itself
	function automatic logic page_locked(input logic [15:0] addr, input logic [7:0] lock);
		logic [7:0] count;
		count = ~lock;
		page_locked = ({3'b000, page_of(addr)} < count)
			|| ((lock != `FG_ERASED_BYTE) && (page_of(addr) == page_of(`FG_LOCK_BYTE_ADDR)));
	endfunction

	// Merge a bus write into a word under its byte enables
	function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wdata,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = wdata[i*8 +: 8];
			end
		end
		merge_be = res;
	endfunction

	// ==========================================================
	// Next state

	always_comb begin
		logic        any_locked;
		logic        exec_locked;
		logic        tgt_locked;
		logic        deny;
		logic        bus_take;
		logic [31:0] rd;
		logic [31:0] wide;
		any_locked  = (s_ff.lock_eff != `FG_ERASED_BYTE);
		exec_locked = page_locked(core_exec_addr, s_ff.lock_eff);
		tgt_locked  = page_locked(core_xwr_addr, s_ff.lock_eff);
		deny        = 1'b0;
		rd          = 32'h0000_0000;
		wide        = 32'h0000_0000;
		bus_take    = avs_write && !s_ff.avs_wait;
		op_start    = 1'b0;
		op_is_erase = 1'b0;
		nxt_s       = s_ff;

		nxt_s.ram_we      = 1'b0;
		nxt_s.ram_re      = 1'b0;
		nxt_s.fl_we       = 1'b0;
		nxt_s.fl_erase    = 1'b0;
		nxt_s.fl_mass     = 1'b0;
		nxt_s.err_reset   = 1'b0;
		nxt_s.dbg_grant   = 1'b0;
		nxt_s.dbg_ignored = 1'b0;

		// Supply monitor status crosses in through two flops
		nxt_s.mon_meta = supply_monitor_on;
		nxt_s.mon_sync = s_ff.mon_meta;

		// Lock byte and error cause are caught once, in the first cycle after reset release
		if (!s_ff.loaded) begin
			nxt_s.loaded   = 1'b1;
			nxt_s.lock_eff = lock_byte_value;
			nxt_s.err_flag = last_reset_flash_error;
		end

		// Read mux
		case (avs_address)
			`FG_OFS_CONTROL: begin
				rd[`FG_BIT_WRITE_ENABLE] = s_ff.write_enable;
				rd[`FG_BIT_ERASE_ENABLE] = s_ff.erase_enable;
			end
			`FG_OFS_KEY:          rd[1:0] = s_ff.key;
			`FG_OFS_RESET_SOURCE: begin
				rd[`FG_BIT_SUPPLY_SEL]  = s_ff.supply_sel;
				rd[`FG_BIT_FLASH_ERROR] = s_ff.err_flag;
			end
			`FG_OFS_WRITE_CYCLES: rd[COUNT_W-1:0] = s_ff.wr_cycles;
			`FG_OFS_ERASE_CYCLES: rd[COUNT_W-1:0] = s_ff.er_cycles;
			`FG_OFS_STATUS: begin
				rd[`FG_BIT_BUSY]                    = busy;
				rd[`FG_BIT_ANY_LOCKED]              = any_locked;
				rd[`FG_LOCK_FIELD_LSB +: 8]         = s_ff.lock_eff;
			end
			default: rd = 32'h0000_0000;
		endcase

		// Bus handshake: one wait cycle, then waitrequest low for one cycle
		if ((avs_read || avs_write) && s_ff.avs_wait) begin
			nxt_s.avs_wait  = 1'b0;
			nxt_s.avs_rdata = rd;
		end else if (!s_ff.avs_wait) begin
			nxt_s.avs_wait = 1'b1;
		end

		// Register writes take effect on the edge where waitrequest is low
		if (bus_take) begin
			case (avs_address)
				`FG_OFS_CONTROL: begin
					if (avs_byteenable[0]) begin
						nxt_s.write_enable = avs_writedata[`FG_BIT_WRITE_ENABLE];
						nxt_s.erase_enable = avs_writedata[`FG_BIT_ERASE_ENABLE];
					end
				end
				`FG_OFS_KEY: begin
					if (avs_byteenable[0]) begin
						// Key sequence; any deviation disables flash until reset
						case (s_ff.key)
							flash_guard_pkg::key_locked:
								nxt_s.key = (avs_writedata[7:0] == `FG_KEY_FIRST) ?
									flash_guard_pkg::key_first : flash_guard_pkg::key_disabled;
							flash_guard_pkg::key_first:
								nxt_s.key = (avs_writedata[7:0] == `FG_KEY_SECOND) ?
									flash_guard_pkg::key_unlocked : flash_guard_pkg::key_disabled;
							default: nxt_s.key = flash_guard_pkg::key_disabled;
						endcase
					end
				end
				`FG_OFS_RESET_SOURCE: begin
					if (avs_byteenable[0]) begin
						nxt_s.supply_sel = avs_writedata[`FG_BIT_SUPPLY_SEL];
					end
				end
				`FG_OFS_WRITE_CYCLES: begin
					wide            = merge_be({{(32-COUNT_W){1'b0}}, s_ff.wr_cycles}, avs_writedata, avs_byteenable);
					nxt_s.wr_cycles = wide[COUNT_W-1:0];
				end
				`FG_OFS_ERASE_CYCLES: begin
					wide            = merge_be({{(32-COUNT_W){1'b0}}, s_ff.er_cycles}, avs_writedata, avs_byteenable);
					nxt_s.er_cycles = wide[COUNT_W-1:0];
				end
				default: ;
			endcase
		end

		// Program-memory reads by firmware are checked for protection
		if (core_cread_valid && !busy) begin
			if (is_reserved(core_cread_addr)) begin
				deny = 1'b1;
			end else if (page_locked(core_cread_addr, s_ff.lock_eff) && !exec_locked) begin
				deny = 1'b1;
			end
		end

		// External-move traffic
		if (core_xwr_valid && !busy) begin
			if (!s_ff.write_enable) begin
				nxt_s.ram_we    = 1'b1;
				nxt_s.ram_addr  = core_xwr_addr;
				nxt_s.ram_wdata = core_xwr_data;
			end else if (!s_ff.mon_sync || !s_ff.supply_sel) begin
				deny = 1'b1;
			end else if (is_reserved(core_xwr_addr)) begin
				deny = 1'b1;
			end else if (s_ff.erase_enable
				&& (page_of(core_xwr_addr) == page_of(`FG_LOCK_BYTE_ADDR))) begin
				deny = 1'b1;
			end else if (!s_ff.erase_enable && any_locked && (core_xwr_addr == `FG_LOCK_BYTE_ADDR)) begin
				deny = 1'b1;
			end else if (tgt_locked && !exec_locked) begin
				deny = 1'b1;
			end else if (s_ff.key != flash_guard_pkg::key_unlocked) begin
				nxt_s.key = flash_guard_pkg::key_disabled;
			end else begin
				// Permitted; exec_locked firmware may reach locked pages here
				op_start       = 1'b1;
				op_is_erase    = s_ff.erase_enable;
				nxt_s.fl_we    = !s_ff.erase_enable;
				nxt_s.fl_erase = s_ff.erase_enable;
				nxt_s.fl_addr  = core_xwr_addr[13:0];
				nxt_s.fl_wdata = s_ff.erase_enable ? `FG_ERASED_BYTE : core_xwr_data;
				nxt_s.key      = flash_guard_pkg::key_locked;
			end
		end else if (core_xrd_valid) begin
			nxt_s.ram_re   = 1'b1;
			nxt_s.ram_addr = core_xrd_addr;
		end

		// A denied firmware access is dropped and a flash-error reset requested
		if (deny) begin
			nxt_s.err_reset = 1'b1;
		end

		// Debug port: prohibited or colliding requests are dropped without reset
		if (dbg_req) begin
			if (busy || op_start || core_xwr_valid) begin
				nxt_s.dbg_ignored = 1'b1;
			end else if (dbg_cmd == flash_guard_pkg::dbg_device_erase) begin
				op_start         = 1'b1;
				op_is_erase      = 1'b1;
				nxt_s.fl_mass    = 1'b1;
				nxt_s.dbg_grant  = 1'b1;
			end else if (is_reserved(dbg_addr) || page_locked(dbg_addr, s_ff.lock_eff)) begin
				nxt_s.dbg_ignored = 1'b1;
			end else begin
				nxt_s.dbg_grant = 1'b1;
				nxt_s.fl_addr   = dbg_addr[13:0];
				case (dbg_cmd)
					flash_guard_pkg::dbg_write: begin
						op_start       = 1'b1;
						nxt_s.fl_we    = 1'b1;
						nxt_s.fl_wdata = dbg_wdata;
					end
					flash_guard_pkg::dbg_page_erase: begin
						op_start       = 1'b1;
						op_is_erase    = 1'b1;
						nxt_s.fl_erase = 1'b1;
						nxt_s.fl_wdata = `FG_ERASED_BYTE;
					end
					default: ;
				endcase
			end
		end
	end

	// ==========================================================
	// Registers

	// Whole block state, frozen while the clock enable is low
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_ff <= RESET_S;
		end else if (ce) begin
			s_ff <= nxt_s;
		end
	end

	// ==========================================================
	// Operation timer

	// Stalls the core for the programmed count
	flash_op_timer #(
		.COUNT_W (COUNT_W)
	) u_timer (
		.core_clk     (core_clk),
		.rst_n        (rst_n),
		.ce           (ce),
		.start        (op_start),
		.is_erase     (op_is_erase),
		.write_cycles (s_ff.wr_cycles),
		.erase_cycles (s_ff.er_cycles),
		.busy         (busy)
	);

	// ==========================================================
	// Outputs

	// All outputs come straight from flops
	assign avs_readdata             = s_ff.avs_rdata;
	assign avs_waitrequest          = s_ff.avs_wait;
	assign core_stall               = busy;
	assign irq_hold                 = busy;
	assign ram_we                   = s_ff.ram_we;
	assign ram_re                   = s_ff.ram_re;
	assign ram_addr                 = s_ff.ram_addr;
	assign ram_wdata                = s_ff.ram_wdata;
	assign flash_we                 = s_ff.fl_we;
	assign flash_erase              = s_ff.fl_erase;
	assign flash_mass_erase         = s_ff.fl_mass;
	assign flash_addr               = s_ff.fl_addr;
	assign flash_wdata              = s_ff.fl_wdata;
	assign flash_error_device_reset = s_ff.err_reset;
	assign dbg_grant                = s_ff.dbg_grant;
	assign dbg_ignored              = s_ff.dbg_ignored;

endmodule

`default_nettype wire

// >>> verification/guard_asserts.sv
// Port-level checks for the flash write and lock guard.
`timescale 1ns/10ps
`default_nettype none
module guard_asserts #(
	parameter int WRITE_CYCLES = 20,
	parameter int ERASE_CYCLES = 40
) (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic        core_xwr_valid,
	input wire logic [15:0] core_xwr_addr,
	input wire logic        core_xrd_valid,
	input wire logic [15:0] core_xrd_addr,
	input wire logic        dbg_req,
	input wire logic [1:0]  dbg_cmd,
	input wire logic [15:0] dbg_addr,
	input wire logic        core_stall,
	input wire logic        ram_re,
	input wire logic [15:0] ram_addr,
	input wire logic        flash_we,
	input wire logic        flash_erase,
	input wire logic        flash_mass_erase,
	input wire logic [7:0]  flash_wdata,
	input wire logic        flash_error_device_reset,
	input wire logic        dbg_grant,
	input wire logic        dbg_ignored,
	input wire logic        irq_hold,
	input wire logic        ram_we
);
	// ==========================================
	// Stall length and the kind of operation behind it
	logic [23:0] run_ff;
	logic        erase_ff;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_ff   <= '0;
			erase_ff <= 1'b0;
		end else begin
			run_ff <= core_stall ? run_ff + 24'h1 : 24'h0;
			if (flash_we || flash_erase || flash_mass_erase)
				erase_ff <= !flash_we;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// ==========================================
	// Properties
	wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not after one wait cycle");
	xrd_ram_a: assert property (core_xrd_valid && !core_xwr_valid && !core_stall |=>
		ram_re && !flash_we && ram_addr == $past(core_xrd_addr)) else $error("external read missed data RAM");
	res_fw_a: assert property (core_xwr_valid && !core_stall && core_xwr_addr >= 16'h3e00 |=>
		!flash_we && !flash_erase && (flash_error_device_reset != ram_we)) else $error("reserved write not refused");
	dbg_res_a: assert property (dbg_req && dbg_cmd != 2'b11 && dbg_addr >= 16'h3e00 |=>
		dbg_ignored && !flash_error_device_reset) else $error("reserved debug access not ignored");
	dbg_ans_a: assert property (dbg_req |=> dbg_grant != dbg_ignored)
		else $error("debug request without single answer");
	mass_a: assert property (dbg_req && dbg_cmd == 2'b11 && !core_stall && !core_xwr_valid |=>
		dbg_grant && flash_mass_erase) else $error("device erase not granted");
	erase_ff_a: assert property (flash_erase |-> flash_wdata == 8'hff)
		else $error("erase data not all ones");
	op_stall_a: assert property (flash_we || flash_erase || flash_mass_erase |-> core_stall)
		else $error("flash operation without stall");
	stall_len_a: assert property ($fell(core_stall) |-> run_ff == (erase_ff ? ERASE_CYCLES : WRITE_CYCLES))
		else $error("stall length wrong");
	irq_hold_a: assert property (core_stall |-> irq_hold)
		else $error("interrupts not held during operation");
endmodule

bind flash_write_and_lock_guard guard_asserts #(.WRITE_CYCLES(WRITE_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) chk (
	.core_clk, .rst_n, .avs_read, .avs_write, .avs_waitrequest, .core_xwr_valid, .core_xwr_addr,
	.core_xrd_valid, .core_xrd_addr, .dbg_req, .dbg_cmd, .dbg_addr, .core_stall, .ram_re, .ram_addr,
	.flash_we, .flash_erase, .flash_mass_erase, .flash_wdata, .flash_error_device_reset, .dbg_grant, .dbg_ignored,
	.irq_hold, .ram_we);
`default_nettype wire

// >>> verification/flash_store_model.sv
// Behavioural program flash array behind the guard's flash strobes.
`timescale 1ns/10ps
`default_nettype none
module flash_store_model (
	input  wire logic        core_clk,
	input  wire logic        flash_we,
	input  wire logic        flash_erase,
	input  wire logic        flash_mass_erase,
	input  wire logic [13:0] flash_addr,
	input  wire logic [7:0]  flash_wdata,
	output logic      [7:0]  lock_byte_value
);
	logic [7:0] mem [0:16383];
	// Blank array at power up
	initial begin
		for (int i = 0; i < 16384; i++)
			mem[i] = 8'hff;
	end
	// Programming only clears bits; erases restore pages
	always @(posedge core_clk) begin
		if (flash_mass_erase) begin
			for (int i = 0; i < 16384; i++)
				mem[i] = 8'hff;
		end else if (flash_erase) begin
			for (int i = 0; i < 512; i++)
				mem[{flash_addr[13:9], i[8:0]}] = 8'hff;
		end else if (flash_we) begin
			mem[flash_addr] = mem[flash_addr] & flash_wdata;
		end
	end
	assign lock_byte_value = mem[14'h3dff];
endmodule
`default_nettype wire

// >>> verification/tb_flash_write_and_lock_guard.sv
// Self-checking bench for the flash write and lock guard.
`timescale 1ns/10ps
`default_nettype none
module tb_flash_write_and_lock_guard;
	logic        core_clk = 0, rst_n = 0, ce = 1, avs_read = 0, avs_write = 0, core_xwr_valid = 0;
	logic        core_xrd_valid = 0, core_cread_valid = 0, last_reset_flash_error = 0, supply_monitor_on = 1;
	logic        dbg_req = 0, avs_waitrequest, core_stall, irq_hold, ram_we, ram_re, flash_we, flash_erase;
	logic        flash_mass_erase, flash_error_device_reset, dbg_grant, dbg_ignored;
	logic [7:0]  avs_address = 0, core_xwr_data = 0, dbg_wdata = 0, lock_byte_value, ram_wdata, flash_wdata;
	logic [15:0] core_xwr_addr = 0, core_xrd_addr = 0, core_cread_addr = 0, core_exec_addr = 0, dbg_addr = 0;
	logic [15:0] ram_addr;
	logic [31:0] avs_writedata = 0, avs_readdata, rd;
	logic [3:0]  avs_byteenable = 4'hf, got;
	logic [1:0]  dbg_cmd = 0;
	logic [13:0] flash_addr;
	int          fails = 0, samples_checked = 0;

	flash_write_and_lock_guard #(.WRITE_CYCLES(20), .ERASE_CYCLES(40)) dut (.*);
	flash_store_model store (.*);

	always #4 core_clk = ~core_clk;

	// ==========================================
	// Tasks
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] want);
		bus(1'b0, a, 32'h0);
		check(rd, want);
	endtask
	// One-cycle external read (prog low) or program read (prog high), answer one cycle later
	task automatic rd_pulse(input logic prog, input logic [15:0] a);
		@(posedge core_clk);
		core_xrd_addr <= a;
		core_cread_addr <= a;
		core_xrd_valid <= !prog;
		core_cread_valid <= prog;
		@(posedge core_clk);
		core_xrd_valid <= 1'b0;
		core_cread_valid <= 1'b0;
		@(posedge core_clk);
		got = {ram_re, flash_we, flash_error_device_reset, ram_we};
	endtask
	task automatic wait_idle;
		while (core_stall !== 1'b0)
			@(posedge core_clk);
	endtask
	task automatic do_reset;
		rst_n <= 1'b0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		bus(1'b1, 8'h08, 32'h2);
	endtask
	task automatic core_wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		core_xwr_addr <= a;
		core_xwr_data <= d;
		core_xwr_valid <= 1'b1;
		@(posedge core_clk);
		core_xwr_valid <= 1'b0;
		@(posedge core_clk);
		got = {flash_we, flash_erase, flash_error_device_reset, ram_we};
		wait_idle;
	endtask
	// Firmware write sequence; the bench posts no interrupts while write-enable is set
	task automatic fw(input logic [31:0] ctl, input logic [15:0] a, input logic [7:0] d);
		bus(1'b1, 8'h04, 32'ha5);
		bus(1'b1, 8'h04, 32'hf1);
		bus(1'b1, 8'h00, ctl);
		core_wr(a, d);
	endtask
	task automatic dbg(input logic [1:0] c, input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		dbg_cmd <= c;
		dbg_addr <= a;
		dbg_wdata <= d;
		dbg_req <= 1'b1;
		@(posedge core_clk);
		dbg_req <= 1'b0;
		@(posedge core_clk);
		got = {dbg_grant, dbg_ignored, flash_we, flash_mass_erase};
		wait_idle;
	endtask

	// ==========================================
	// Test sequence
	initial begin
		do_reset;
		rchk(8'h00, 32'h0);
		rchk(8'h0c, 32'd20);
		rchk(8'h10, 32'd40);
		rchk(8'h18, 32'h0);
		rchk(8'h14, 32'hff00);
		fw(32'h1, 16'h0100, 8'h5a);
		check(got, 4'b1000);
		check(store.mem[16'h0100], 8'h5a);
		rchk(8'h04, 32'h0);
		fw(32'h1, 16'h0100, 8'h0f);
		check(store.mem[16'h0100], 8'h0a);
		fw(32'h3, 16'h01f0, 8'h00);
		check(got, 4'b0100);
		check(store.mem[16'h0100], 8'hff);
		rd_pulse(1'b0, 16'h0123);
		check(got, 4'b1000);
		check(ram_addr, 16'h0123);
		bus(1'b1, 8'h00, 32'h0);
		core_wr(16'h0100, 8'h11);
		check(got, 4'b0001);
		check({ram_addr, ram_wdata}, 24'h010011);
		bus(1'b1, 8'h00, 32'h1);
		core_wr(16'h0100, 8'h22);
		check(got, 4'b0000);
		bus(1'b1, 8'h04, 32'ha5);
		bus(1'b1, 8'h04, 32'hf1);
		rchk(8'h04, 32'h3);
		do_reset;
		bus(1'b1, 8'h04, 32'hf1);
		rchk(8'h04, 32'h3);
		do_reset;
		fw(32'h1, 16'h3e10, 8'h00);
		check(got, 4'b0010);
		dbg(flash_guard_pkg::dbg_write, 16'h3f00, 8'h00);
		check(got, 4'b0100);
		last_reset_flash_error <= 1'b1;
		do_reset;
		last_reset_flash_error <= 1'b0;
		rchk(8'h08, 32'h42);
		supply_monitor_on <= 1'b0;
		fw(32'h1, 16'h0200, 8'h00);
		check(got, 4'b0010);
		supply_monitor_on <= 1'b1;
		do_reset;
		fw(32'h1, 16'h3dff, 8'hfd);
		check(got, 4'b1000);
		rchk(8'h14, 32'hff00);
		do_reset;
		rchk(8'h14, 32'hfd02);
		core_exec_addr <= 16'h1000;
		fw(32'h1, 16'h0200, 8'h00);
		check(got, 4'b0010);
		rd_pulse(1'b1, 16'h0000);
		check(got, 4'b0010);
		rd_pulse(1'b1, 16'h3e00);
		check(got, 4'b0010);
		do_reset;
		fw(32'h1, 16'h0400, 8'h00);
		check(got, 4'b1000);
		fw(32'h1, 16'h3c00, 8'h00);
		check(got, 4'b0010);
		do_reset;
		core_exec_addr <= 16'h0000;
		fw(32'h1, 16'h0300, 8'h3c);
		check(got, 4'b1000);
		rd_pulse(1'b1, 16'h3c00);
		check(got, 4'b0000);
		fw(32'h3, 16'h3c00, 8'h00);
		check(got, 4'b0010);
		do_reset;
		fw(32'h1, 16'h3dff, 8'hfc);
		check(got, 4'b0010);
		do_reset;
		dbg(flash_guard_pkg::dbg_read, 16'h0000, 8'h00);
		check(got, 4'b0100);
		dbg(flash_guard_pkg::dbg_page_erase, 16'h0000, 8'h00);
		check(got, 4'b0100);
		dbg(flash_guard_pkg::dbg_write, 16'h3c00, 8'h00);
		check(got, 4'b0100);
		dbg(flash_guard_pkg::dbg_device_erase, 16'h0000, 8'h00);
		check(got, 4'b1001);
		check(store.mem[16'h3dff], 8'hff);
		dbg(flash_guard_pkg::dbg_write, 16'h0800, 8'h5a);
		check(got, 4'b1010);
		check(store.mem[16'h0800], 8'h5a);
		dbg(flash_guard_pkg::dbg_read, 16'h0800, 8'h00);
		check(got, 4'b1000);
		rchk(8'h14, 32'hfd02);
		do_reset;
		rchk(8'h14, 32'hff00);
		print_verdict;
	end

	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		print_verdict;
	end
endmodule
`default_nettype wire
